// File: src/board_decode_pkg.sv
// Shared constants for the board address decoder.
// Assumes a single 40 MHz clock and byte addresses from the processor core.
package board_decode_pkg;
  localparam int unsigned clk_mhz = 40;
  localparam int unsigned addr_w = 24;
  // Processor byte address map; the sync and async I/O bounds are word addresses
  localparam logic [23:0] low_region_top = 24'h03FFFF;
  localparam logic [23:0] ext_mem_top = 24'h7FFFFF;
  localparam logic [23:0] ext_mem_small_top = 24'h03FFFF;
  localparam logic [23:0] eprom_int_base = 24'hF80000;
  localparam logic [23:0] lp_sram_base = 24'hF40000;
  localparam logic [23:0] socket_base = 24'hFC0000;
  localparam logic [5:0] region_mask_bits = 6'h12;
  localparam logic [22:0] sync_io_base = 23'h400000;
  localparam logic [22:0] sync_io_top = 23'h4003FF;
  localparam logic [22:0] async_io_base = 23'h410000;
  localparam logic [22:0] async_io_top = 23'h4103FF;
  localparam logic [23:0] int_io_base = 24'h810000;
  localparam logic [23:0] int_io_mask = 24'hFF0000;
  // Internal register and peripheral chip byte addresses
  localparam logic [23:0] memory_map_select_addr = 24'h810061;
  localparam logic [23:0] watchdog_kick_addr = 24'h810069;
  localparam logic [23:0] top_level_irq_cause_addr = 24'h810071;
  localparam logic [23:0] clock_dev_lo = 24'h810041;
  localparam logic [23:0] clock_dev_hi = 24'h81005F;
  localparam logic [23:0] serial_lo = 24'h810021;
  localparam logic [23:0] serial_hi = 24'h810027;
  localparam logic [23:0] ctr_par_lo = 24'h810001;
  localparam logic [23:0] ctr_par_hi = 24'h810007;
  // Cause register bit positions
  localparam int unsigned cause_abort_bit = 0;
  localparam int unsigned cause_nmi_bit = 1;
  localparam int unsigned cause_wdf_bit = 2;
  localparam int unsigned cause_pwf_bit = 7;
  localparam logic [7:0] cause_reset = 8'h00;
  localparam logic [1:0] map_reset = 2'h0;
  // Timing
  localparam int unsigned timeout_short_us = 8;
  localparam int unsigned timeout_long_us = 16;
  localparam int unsigned timeout_short_cycles = timeout_short_us * clk_mhz;
  localparam int unsigned timeout_long_cycles = timeout_long_us * clk_mhz;
  localparam int unsigned sync_fast_mhz = 2;
  localparam int unsigned sync_slow_mhz = 1;
  localparam int unsigned sync_fast_div = clk_mhz / sync_fast_mhz;
  localparam int unsigned sync_slow_div = clk_mhz / sync_slow_mhz;
  localparam int unsigned eprom_fast_ns = 120;
  localparam int unsigned on_level = 3'h6;
  localparam int unsigned top_level = 3'h7;

  typedef enum logic [3:0] {
    tgt_none = 4'h0,
    tgt_eprom = 4'h1,
    tgt_lp_sram = 4'h2,
    tgt_socket = 4'h3,
    tgt_ext_mem = 4'h4,
    tgt_sync_io = 4'h5,
    tgt_async_io = 4'h6,
    tgt_int_reg = 4'h7,
    tgt_clock_dev = 4'h8,
    tgt_serial = 4'h9,
    tgt_ctr_par = 4'hA,
    tgt_reserved = 4'hB
  } target_t;
endpackage

// File: src/sync_enable_div.sv
// Divider making the one-cycle enable that paces synchronous bus transfers.
// Assumes the 40 MHz clock; rate select is a static level.
`default_nettype none
module sync_enable_div #(
  parameter int unsigned slow_div = board_decode_pkg::sync_slow_div,
  parameter int unsigned fast_div = board_decode_pkg::sync_fast_div
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic fast_sel,
  output logic enable_pulse
);
  initial
  begin
    if (fast_div < 2 || slow_div < fast_div || slow_div > 256)
      $error("sync_enable_div: bad divide ratios");
  end

  logic [7:0] count_q;
  logic [7:0] limit;

  assign limit = fast_sel ? 8'(fast_div - 1) : 8'(slow_div - 1);

  always_ff @(posedge clk)
  begin
    if (reset || count_q >= limit)
      count_q <= 8'h00;
    else
      count_q <= count_q + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      enable_pulse <= 1'b0;
    else
      enable_pulse <= (count_q >= limit);
  end
endmodule
`default_nettype wire

// File: src/level7_cause.sv
// Level-7 source latches and cause register.
// Assumes source lines are active low and synchronous to clk.
`default_nettype none
module level7_cause (
  input wire logic clk,
  input wire logic reset,
  input wire logic abort_n,
  input wire logic nmi_n,
  input wire logic wdf_n,
  input wire logic power_fail_line_n,
  input wire logic clear_we,
  input wire logic [7:0] clear_data,
  output logic [7:0] cause,
  output logic top_request
);
  logic [3:0] src_now;
  logic [3:0] src_prev_q;
  logic [3:0] flag_q;
  logic [3:0] fall;
  logic [3:0] clr;

  assign src_now = {power_fail_line_n, wdf_n, nmi_n, abort_n};
  assign fall = src_prev_q & ~src_now;
  assign clr = clear_we ? {clear_data[board_decode_pkg::cause_pwf_bit],
                           clear_data[board_decode_pkg::cause_wdf_bit],
                           clear_data[board_decode_pkg::cause_nmi_bit],
                           clear_data[board_decode_pkg::cause_abort_bit]} : 4'h0;

  always_ff @(posedge clk)
  begin
    if (reset)
      src_prev_q <= 4'hF;
    else
      src_prev_q <= src_now;
  end

  // Falling edge sets; set beats clear. Power-fail stays while line is low.
  always_ff @(posedge clk)
  begin
    if (reset)
      flag_q <= 4'h0;
    else
    begin
      flag_q <= (flag_q & ~clr) | fall;
      if (!power_fail_line_n)
        flag_q[3] <= 1'b1;
    end
  end

  always_comb
  begin
    cause = board_decode_pkg::cause_reset;
    cause[board_decode_pkg::cause_abort_bit] = flag_q[0];
    cause[board_decode_pkg::cause_nmi_bit] = flag_q[1];
    cause[board_decode_pkg::cause_wdf_bit] = flag_q[2];
    cause[board_decode_pkg::cause_pwf_bit] = flag_q[3];
  end

  assign top_request = |flag_q;
endmodule
`default_nettype wire

// File: src/board_address_decoder.sv
// Address decoder and bus-interface control for the processor board.
// Assumes a processor core giving byte address, strobes and a cycle request,
// and a backplane bus, memories and peripherals answering with ready.
// Contract
// - Reset maps low region onto internal EPROM
// - Map bits choose the low-region target
// - Bus uses word address and byte strobes
// - Timeout ends stuck async transfer, 8/16us
// - EPROM zero-wait allowed with fast parts
// - Sync transfers paced by 1/2 MHz enable
// - Sync I/O window 400000-4003FF with strobe
// - Async I/O window 410000-4103FF decoded
// - External I/O accessed as whole words
// - External memory 256KB narrow, 8MB wide
// - Internal control register byte addresses decoded
// - Peripheral chip byte ranges decoded
// - Bus DMA never reaches local RAM
// - Levels 1-5 vectored/auto; on-board on 6
// - Four sources raise level 7, cause shown
// - Watchdog expiry resets or raises level 7
// - Map bits 1:0 at 810061, reset cleared
// - Sources latched on falling edge until cleared
`default_nettype none
module board_address_decoder #(
  parameter int unsigned wdog_cycles = 40000000,
  parameter int unsigned timeout_short = board_decode_pkg::timeout_short_cycles,
  parameter int unsigned timeout_long = board_decode_pkg::timeout_long_cycles
) (
  input wire logic clk,
  input wire logic reset,
  // Processor side
  input wire logic cpu_req,
  input wire logic [23:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic cpu_uds,
  input wire logic cpu_lds,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  output logic cpu_ack,
  output logic cpu_berr,
  // Configuration straps
  input wire logic wide_bus,
  input wire logic timeout_long_sel,
  input wire logic sync_fast_sel,
  input wire logic [1:0] eprom_waits_sel,
  input wire logic sram_wait_sel,
  input wire logic wdog_irq_mode,
  input wire logic [4:0] bus_irq_vectored,
  // Memory and peripheral selects
  output logic sel_eprom,
  output logic sel_lp_sram,
  output logic sel_socket,
  output logic sel_clock_dev,
  output logic sel_serial,
  output logic sel_ctr_par,
  input wire logic [15:0] local_rdata,
  // Backplane bus
  output logic [22:0] bus_addr,
  output logic bus_ds0,
  output logic bus_ds1,
  output logic bus_write,
  output logic bus_async_strobe,
  output logic valid_peripheral_strobe,
  output logic sync_enable,
  input wire logic bus_ready,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_dma_grant,
  output logic local_ram_block,
  // Interrupt lines
  input wire logic [4:0] bus_irq_n,
  input wire logic onboard_irq,
  input wire logic abort_n,
  input wire logic nmi_n,
  input wire logic power_fail_line_n,
  output logic [2:0] cpu_ipl,
  output logic cpu_autovector,
  output logic wdog_reset
);
  initial
  begin
    if (timeout_short < 1 || timeout_long < timeout_short || wdog_cycles < 2
        || timeout_long > 65535)
      $error("board_address_decoder: bad timing parameters");
  end
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_wait = 4'b0010,
    st_bus = 4'b0100,
    st_done = 4'b1000
  } cyc_state_t;
  cyc_state_t state_q;
  logic [1:0] map_q;
  logic map_select_high, map_select_low;
  board_decode_pkg::target_t tgt, tgt_q;
  logic [23:0] addr_q;
  logic write_q, uds_q, lds_q;
  logic [2:0] wait_cnt_q, wait_need;
  logic [15:0] timeout_q, timeout_lim, rdata_q;
  logic [31:0] wdog_q;
  logic wdf_n_q;
  logic [7:0] cause;
  logic top_request;
  logic int_reg_we, cause_we, kick;
  logic sync_tick, sync_seen_q, is_ext, bus_done, bus_expired;
  assign map_select_high = map_q[1];
  assign map_select_low = map_q[0];
  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction
  // Address decode of the processor byte address
  always_comb
  begin
    logic [22:0] word;
    word = cpu_addr[23:1];
    tgt = board_decode_pkg::tgt_none;
    if (cpu_addr <= board_decode_pkg::low_region_top)
    begin
      unique case ({map_select_high, map_select_low})
        2'b00: tgt = board_decode_pkg::tgt_eprom;
        2'b01: tgt = board_decode_pkg::tgt_lp_sram;
        2'b10: tgt = board_decode_pkg::tgt_socket;
        2'b11: tgt = board_decode_pkg::tgt_ext_mem;
      endcase
    end
    else if (cpu_addr[23:18] == 6'h3E)
      tgt = board_decode_pkg::tgt_eprom;
    else if (cpu_addr[23:18] == 6'h3D)
      tgt = board_decode_pkg::tgt_lp_sram;
    else if (cpu_addr[23:18] == 6'h3F)
      tgt = board_decode_pkg::tgt_socket;
    else if (word >= board_decode_pkg::sync_io_base && word <= board_decode_pkg::sync_io_top)
      tgt = board_decode_pkg::tgt_sync_io;
    else if (word >= board_decode_pkg::async_io_base && word <= board_decode_pkg::async_io_top)
      tgt = board_decode_pkg::tgt_async_io;
    else if ((cpu_addr & board_decode_pkg::int_io_mask) == board_decode_pkg::int_io_base)
    begin
      if (cpu_addr == board_decode_pkg::memory_map_select_addr
          || cpu_addr == board_decode_pkg::watchdog_kick_addr
          || cpu_addr == board_decode_pkg::top_level_irq_cause_addr)
        tgt = board_decode_pkg::tgt_int_reg;
      else if (in_range(cpu_addr, board_decode_pkg::clock_dev_lo, board_decode_pkg::clock_dev_hi))
        tgt = board_decode_pkg::tgt_clock_dev;
      else if (in_range(cpu_addr, board_decode_pkg::serial_lo, board_decode_pkg::serial_hi))
        tgt = board_decode_pkg::tgt_serial;
      else if (in_range(cpu_addr, board_decode_pkg::ctr_par_lo, board_decode_pkg::ctr_par_hi))
        tgt = board_decode_pkg::tgt_ctr_par;
      else
        tgt = board_decode_pkg::tgt_reserved;
    end
    else if (cpu_addr <= (wide_bus ? board_decode_pkg::ext_mem_top
                                   : board_decode_pkg::ext_mem_small_top))
      tgt = board_decode_pkg::tgt_ext_mem;
    else
      tgt = board_decode_pkg::tgt_reserved;
  end

  // Wait states: EPROM 0,1,2,4 and SRAM 0,1; zero suits 120 ns parts
  always_comb
  begin
    wait_need = 3'h0;
    if (tgt_q == board_decode_pkg::tgt_eprom || tgt_q == board_decode_pkg::tgt_socket)
      wait_need = (eprom_waits_sel == 2'h3) ? 3'h4 : {1'b0, eprom_waits_sel};
    else if (tgt_q == board_decode_pkg::tgt_lp_sram)
      wait_need = {2'h0, sram_wait_sel};
  end

  assign is_ext = (tgt_q == board_decode_pkg::tgt_ext_mem)
               || (tgt_q == board_decode_pkg::tgt_sync_io)
               || (tgt_q == board_decode_pkg::tgt_async_io);
  assign timeout_lim = timeout_long_sel ? 16'(timeout_long) : 16'(timeout_short);
  assign bus_done = bus_ready && (tgt_q != board_decode_pkg::tgt_sync_io || sync_seen_q);
  assign bus_expired = timeout_q >= timeout_lim - 16'h0001;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= st_idle;
      tgt_q <= board_decode_pkg::tgt_none;
      addr_q <= 24'h000000;
      write_q <= 1'b0;
      uds_q <= 1'b0;
      lds_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        st_idle:
          if (cpu_req)
          begin
            tgt_q <= tgt;
            addr_q <= cpu_addr;
            write_q <= cpu_write;
            uds_q <= cpu_uds;
            lds_q <= cpu_lds;
            state_q <= st_wait;
          end
        st_wait:
          if (wait_cnt_q >= wait_need)
            state_q <= is_ext ? st_bus : st_done;
        st_bus:
          if (bus_done || bus_expired)
            state_q <= st_done;
        st_done:
          state_q <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || state_q != st_wait)
      wait_cnt_q <= 3'h0;
    else
      wait_cnt_q <= wait_cnt_q + 3'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset || state_q != st_bus)
      timeout_q <= 16'h0000;
    else
      timeout_q <= timeout_q + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (reset || state_q != st_bus)
      sync_seen_q <= 1'b0;
    else if (sync_tick)
      sync_seen_q <= 1'b1;
  end

  // Answer and read data
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cpu_ack <= 1'b0;
      cpu_berr <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      cpu_ack <= 1'b0;
      cpu_berr <= 1'b0;
      if (state_q == st_bus && bus_expired && !bus_done)
        cpu_berr <= 1'b1;
      else if ((state_q == st_bus && bus_done)
               || (state_q == st_wait && wait_cnt_q >= wait_need && !is_ext))
      begin
        cpu_ack <= 1'b1;
        if (is_ext)
          rdata_q <= bus_rdata;
        else if (tgt_q == board_decode_pkg::tgt_int_reg
                 && addr_q == board_decode_pkg::top_level_irq_cause_addr)
          rdata_q <= {8'h00, cause};
        else
          rdata_q <= local_rdata;
      end
    end
  end
  assign cpu_rdata = rdata_q;

  // Internal register writes take effect at the acknowledge
  assign int_reg_we = (state_q == st_wait) && (wait_cnt_q >= wait_need) && write_q
                    && (tgt_q == board_decode_pkg::tgt_int_reg) && lds_q;
  assign cause_we = int_reg_we && addr_q == board_decode_pkg::top_level_irq_cause_addr;
  assign kick = int_reg_we && addr_q == board_decode_pkg::watchdog_kick_addr;

  always_ff @(posedge clk)
  begin
    if (reset)
      map_q <= board_decode_pkg::map_reset;
    else if (int_reg_we && addr_q == board_decode_pkg::memory_map_select_addr)
      map_q <= cpu_wdata[1:0];
  end

  // Watchdog: expiry gives a reset pulse or a level-7 source
  always_ff @(posedge clk)
  begin
    if (reset || kick || wdog_q >= wdog_cycles - 1)
      wdog_q <= 32'h00000000;
    else
      wdog_q <= wdog_q + 32'h00000001;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wdf_n_q <= 1'b1;
      wdog_reset <= 1'b0;
    end
    else
    begin
      wdf_n_q <= !(wdog_irq_mode && wdog_q >= wdog_cycles - 1);
      wdog_reset <= !wdog_irq_mode && wdog_q >= wdog_cycles - 1;
    end
  end

  level7_cause u_cause (
    .clk(clk),
    .reset(reset),
    .abort_n(abort_n),
    .nmi_n(nmi_n),
    .wdf_n(wdf_n_q),
    .power_fail_line_n(power_fail_line_n),
    .clear_we(cause_we),
    .clear_data(cpu_wdata[7:0]),
    .cause(cause),
    .top_request(top_request)
  );

  sync_enable_div u_div (
    .clk(clk),
    .reset(reset),
    .fast_sel(sync_fast_sel),
    .enable_pulse(sync_tick)
  );
  assign sync_enable = sync_tick;
  // Interrupt priority encoder
  always_comb
  begin
    cpu_ipl = 3'h0;
    cpu_autovector = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      if (!bus_irq_n[i])
      begin
        cpu_ipl = 3'(i + 1);
        cpu_autovector = !bus_irq_vectored[i];
      end
    end
    if (onboard_irq)
    begin
      cpu_ipl = 3'(board_decode_pkg::on_level);
      cpu_autovector = 1'b0;
    end
    if (top_request)
    begin
      cpu_ipl = 3'(board_decode_pkg::top_level);
      cpu_autovector = 1'b1;
    end
  end
  // Bus drive: word address, byte strobes, whole words for I/O
  assign bus_addr = addr_q[23:1];
  assign bus_ds0 = (state_q == st_bus) && (lds_q || tgt_q != board_decode_pkg::tgt_ext_mem);
  assign bus_ds1 = (state_q == st_bus) && (uds_q || tgt_q != board_decode_pkg::tgt_ext_mem);
  assign bus_write = write_q;
  assign bus_async_strobe = (state_q == st_bus) && tgt_q != board_decode_pkg::tgt_sync_io;
  assign valid_peripheral_strobe = (state_q == st_bus)
                                 && tgt_q == board_decode_pkg::tgt_sync_io;
  assign local_ram_block = bus_dma_grant;
  // Local memory selects are withheld while a bus master holds the board; peripheral selects are not
  assign sel_eprom = !bus_dma_grant && state_q == st_wait && tgt_q == board_decode_pkg::tgt_eprom;
  assign sel_lp_sram = !bus_dma_grant && state_q == st_wait
                    && tgt_q == board_decode_pkg::tgt_lp_sram;
  assign sel_socket = !bus_dma_grant && state_q == st_wait
                   && tgt_q == board_decode_pkg::tgt_socket;
  assign sel_clock_dev = state_q == st_wait && tgt_q == board_decode_pkg::tgt_clock_dev;
  assign sel_serial = state_q == st_wait && tgt_q == board_decode_pkg::tgt_serial;
  assign sel_ctr_par = state_q == st_wait && tgt_q == board_decode_pkg::tgt_ctr_par;
endmodule
`default_nettype wire

// File: tb/board_address_decoder_assertions.sv
// Checker for the board address decoder, watching top-level ports only.
// Assumes it is bound into the decoder by the bench.
`default_nettype none
module board_address_decoder_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic cpu_berr,
  input wire logic [22:0] bus_addr,
  input wire logic bus_ds0,
  input wire logic bus_ds1,
  input wire logic bus_async_strobe,
  input wire logic valid_peripheral_strobe,
  input wire logic sync_enable,
  input wire logic bus_dma_grant,
  input wire logic local_ram_block,
  input wire logic sel_lp_sram,
  input wire logic onboard_irq,
  input wire logic nmi_n,
  input wire logic [2:0] cpu_ipl,
  input wire logic wdog_irq_mode,
  input wire logic wdog_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_dma; bus_dma_grant |-> local_ram_block && !sel_lp_sram; endproperty
  a_dma: assert property (p_dma) else $error("dma reaches local ram");
  property p_sync_win; valid_peripheral_strobe |-> bus_addr[22:10] == 13'h1000; endproperty
  a_sync_win: assert property (p_sync_win) else $error("sync strobe off window");
  property p_io_word; valid_peripheral_strobe |-> bus_ds0 && bus_ds1; endproperty
  a_io_word: assert property (p_io_word) else $error("io not word wide");
  property p_nmi_top; $fell(nmi_n) |-> ##[1:3] cpu_ipl == 3'h7; endproperty
  a_nmi_top: assert property (p_nmi_top) else $error("nmi edge lost");
  property p_onboard; onboard_irq |-> ##[0:2] cpu_ipl >= 3'h6; endproperty
  a_onboard: assert property (p_onboard) else $error("onboard level low");
  property p_berr_bus; cpu_berr |-> $past(bus_async_strobe || valid_peripheral_strobe); endproperty
  a_berr_bus: assert property (p_berr_bus) else $error("berr outside bus phase");
  property p_en_gap; sync_enable |=> !sync_enable [*8]; endproperty
  a_en_gap: assert property (p_en_gap) else $error("enable too fast");
  property p_wdog_mode; wdog_irq_mode |=> !wdog_reset; endproperty
  a_wdog_mode: assert property (p_wdog_mode) else $error("reset in irq mode");
  c_berr: cover property (cpu_berr);
  c_sync: cover property (valid_peripheral_strobe);
  c_wdog: cover property (wdog_reset);
endmodule
`default_nettype wire

// File: tb/bus_target_model.sv
// Backplane target answering the decoder's bus phase with ready and data.
// Assumes sel is the OR of both bus strobes; stall withholds ready.
`default_nettype none
module bus_target_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic sel,
  input wire logic [22:0] addr,
  output logic ready,
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen_q;
  initial
  begin
    {seen_q, ready, rdata} = 18'h0;
  end
  // Released data toggles so a stale value never looks valid
  always @(posedge clk)
  begin
    seen_q <= #1 sel;
    ready <= #1 sel && seen_q && !stall;
    rdata <= #1 (sel && seen_q) ? {addr[14:0], 1'b1} : ~rdata;
  end
endmodule
`default_nettype wire

// File: tb/test_board_address_decoder.sv
// Self-checking bench for the board address decoder.
// Assumes decoder, package, checker and bus target model compiled first.
`default_nettype none
module test_board_address_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, cpu_req, cpu_write, cpu_uds, cpu_lds, cpu_ack, cpu_berr, err;
  logic [23:0] cpu_addr;
  logic [15:0] cpu_wdata, cpu_rdata, bus_rdata, local_rdata, rd;
  logic wide_bus, timeout_long_sel, sync_fast_sel, sram_wait_sel, wdog_irq_mode, onboard_irq;
  logic [1:0] eprom_waits_sel, bds;
  logic [4:0] bus_irq_vectored, bus_irq_n;
  logic sel_eprom, sel_lp_sram, sel_socket, sel_clock_dev, sel_serial, sel_ctr_par;
  logic [22:0] bus_addr, baddr;
  logic bus_ds0, bus_ds1, bus_write, bus_async_strobe, valid_peripheral_strobe, sync_enable;
  logic bus_ready, bus_dma_grant, local_ram_block, abort_n, nmi_n, power_fail_line_n;
  logic [2:0] cpu_ipl;
  logic cpu_autovector, wdog_reset, stall, bw;
  logic [7:0] seen;
  int fails, check_count, lat;
  logic [7:0] mexp [4] = '{8'h80, 8'h40, 8'h20, 8'h02};
  logic [7:0] cexp [3] = '{8'h01, 8'h02, 8'h80};
  logic [23:0] ta [13] = '{24'h810041, 24'h81005F, 24'h810021, 24'h810027, 24'h810001,
    24'h810007, 24'h800000, 24'h8007FE, 24'h820000, 24'h8207FE, 24'h100000, 24'h810011,
    24'h810061};
  logic [7:0] ts [13] = '{8'h10, 8'h10, 8'h08, 8'h08, 8'h04, 8'h04, 8'h01, 8'h01, 8'h02,
    8'h02, 8'h02, 8'h00, 8'h00};
  assign local_rdata = ~cpu_addr[15:0];
  board_address_decoder #(.wdog_cycles(2000), .timeout_short(50), .timeout_long(100)) u_dut (.*);
  bus_target_model u_bus (.clk, .stall, .sel(bus_async_strobe | valid_peripheral_strobe),
    .addr(bus_addr), .ready(bus_ready), .rdata(bus_rdata));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One processor cycle; lat counts edges from take to answer
  task automatic acc(input logic [23:0] a, input logic w, input logic [15:0] d,
    input logic [1:0] be);
    {cpu_addr, cpu_write, cpu_wdata, cpu_uds, cpu_lds, cpu_req} = {a, w, d, be, 1'b1};
    seen = 8'h00;
    lat = 0;
    @(posedge clk);
    #1 cpu_req = 1'b0;
    while (cpu_ack !== 1'b1 && cpu_berr !== 1'b1 && lat < 400)
    begin
      seen |= {sel_eprom, sel_lp_sram, sel_socket, sel_clock_dev, sel_serial, sel_ctr_par,
        bus_async_strobe, valid_peripheral_strobe};
      if (bus_async_strobe || valid_peripheral_strobe)
        {baddr, bds, bw} = {bus_addr, bus_ds1, bus_ds0, bus_write};
      @(posedge clk);
      #1 lat++;
    end
    if (lat == 400)
      chk(lat, 24'h0);
    {rd, err} = {cpu_rdata, cpu_berr};
    cyc(1);
  endtask
  task automatic test_done();
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #750us;
    fails++;
    test_done();
  end
  initial
  begin
    {reset, cpu_req, cpu_write, cpu_uds, cpu_lds, stall, onboard_irq, bus_dma_grant} = 8'h80;
    {cpu_addr, cpu_wdata, abort_n, nmi_n, power_fail_line_n} = 43'h7;
    {wide_bus, timeout_long_sel, sync_fast_sel, sram_wait_sel, wdog_irq_mode} = 5'h10;
    {eprom_waits_sel, bus_irq_vectored, bus_irq_n} = 12'h15F;
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    acc(24'h000010, 1'b0, 16'h0, 2'h3);
    chk(seen, 8'h80);
    for (int m = 1; m < 5; m++)
    begin
      acc(24'h810061, 1'b1, {8'h0, 6'h3F, m[1:0]}, 2'h1);
      acc(24'h000010, 1'b0, 16'h0, 2'h3);
      chk(seen, mexp[m[1:0]]);
    end
    for (int i = 0; i < 13; i++)
    begin
      acc(ta[i], 1'b0, 16'h0, 2'h3);
      chk(seen, ts[i]);
      if (ts[i][1:0] != 2'h0)
        chk(baddr, ta[i][23:1]);
    end
    acc(24'h100000, 1'b0, 16'h0, 2'h2);
    chk(bds, 2'h2);
    acc(24'h100000, 1'b1, 16'h0, 2'h3);
    chk({bw, bds}, 3'h7);
    acc(24'h800002, 1'b0, 16'h0, 2'h1);
    chk({bds, rd}, {2'h3, 16'h0003});
    wide_bus = 1'b0;
    acc(24'h100000, 1'b0, 16'h0, 2'h3);
    chk(seen, 8'h00);
    wide_bus = 1'b1;
    for (int e = 0; e < 4; e++)
    begin
      eprom_waits_sel = e[1:0];
      acc(24'hF80000, 1'b0, 16'h0, 2'h3);
      chk(lat, 1 + (e == 3 ? 4 : e));
    end
    for (int s = 0; s < 2; s++)
    begin
      sram_wait_sel = s[0];
      acc(24'hF40000, 1'b0, 16'h0, 2'h3);
      chk(lat, 1 + s);
    end
    stall = 1'b1;
    for (int t = 1; t < 3; t++)
    begin
      timeout_long_sel = t[1];
      acc(24'h820000, 1'b0, 16'h0, 2'h3);
      chk({err, lat >= 50 * t && lat <= 50 * t + 5}, 2'h3);
    end
    stall = 1'b0;
    for (int f = 0; f < 2; f++)
    begin
      sync_fast_sel = f[0];
      cyc(50);
      @(posedge clk iff sync_enable === 1'b1);
      lat = 0;
      do
      begin
        @(posedge clk);
        lat++;
      end while (sync_enable !== 1'b1 && lat < 100);
      #1 chk(lat, f ? 20 : 40);
    end
    for (int l = 1; l < 6; l++)
    begin
      bus_irq_n = ~(5'h01 << (l - 1));
      cyc(3);
      chk({cpu_ipl, cpu_autovector}, {l[2:0], ~bus_irq_vectored[l - 1]});
    end
    {bus_irq_n, onboard_irq, bus_dma_grant} = 7'h7F;
    cyc(3);
    chk({cpu_ipl, local_ram_block}, 4'hD);
    {onboard_irq, bus_dma_grant} = 2'h0;
    acc(24'h810011, 1'b1, 16'hFFFF, 2'h3);
    for (int k = 0; k < 3; k++)
    begin
      {power_fail_line_n, nmi_n, abort_n} = ~(3'h1 << k);
      cyc(2);
      {power_fail_line_n, nmi_n, abort_n} = 3'h7;
      cyc(2);
      acc(24'h810071, 1'b0, 16'h0, 2'h1);
      chk({rd[7:0], cpu_ipl}, {cexp[k], 3'h7});
      acc(24'h810071, 1'b1, {8'h0, cexp[k]}, 2'h1);
      acc(24'h810071, 1'b0, 16'h0, 2'h1);
      chk({rd[7:0], cpu_ipl}, 11'h0);
    end
    acc(24'h810069, 1'b1, 16'h0, 2'h1);
    lat = 0;
    while (wdog_reset !== 1'b1 && lat < 3000)
    begin
      @(posedge clk);
      #1 lat++;
    end
    chk(lat > 1980 && lat < 2005, 1'b1);
    wdog_irq_mode = 1'b1;
    acc(24'h810069, 1'b1, 16'h0, 2'h1);
    cyc(2100);
    acc(24'h810071, 1'b0, 16'h0, 2'h1);
    chk({rd[2], cpu_ipl}, 4'hF);
    test_done();
  end
endmodule
bind board_address_decoder board_address_decoder_checker u_chk (.*);
`default_nettype wire
